// ### fcd_pkg.sv
package fcd_pkg;

    // Bus clock
    localparam int CLK_NS = 20;

    // Write strobe width, rounded up to whole cycles
    localparam int WE_LOW_NS = 35;
    localparam logic [3:0] WE_LOW_CYC = 4'((WE_LOW_NS + CLK_NS - 1) / CLK_NS);

    // Read access time; the strobe also covers the two-flop input path
    localparam int RD_ACC_NS = 70;
    localparam logic [3:0] RD_ACC_CYC = 4'((RD_ACC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] SYNC_CYC = 4'd2;
    localparam logic [3:0] RD_STROBE_CYC = RD_ACC_CYC + SYNC_CYC;

    // Time before the ready pin is trusted after a final write
    localparam int BUSY_NS = 90;
    localparam logic [3:0] BUSY_CYC = 4'((BUSY_NS + CLK_NS - 1) / CLK_NS);

    // Sector erase queueing window, longest time so rounded down
    localparam int ERASE_WIN_NS = 50000;
    localparam logic [11:0] ERASE_WIN_CYC = 12'(ERASE_WIN_NS / CLK_NS);
    localparam logic [11:0] WIN_GUARD_CYC = 12'h010;
    localparam logic [11:0] WIN_ACCEPT_CYC = ERASE_WIN_CYC - WIN_GUARD_CYC;

    // Command addresses, word and byte mode
    localparam logic [19:0] CA_UNLOCK1_W = 20'h00555;
    localparam logic [19:0] CA_UNLOCK2_W = 20'h002aa;
    localparam logic [19:0] CA_UNLOCK1_B = 20'h00aaa;
    localparam logic [19:0] CA_UNLOCK2_B = 20'h00555;
    localparam logic [19:0] CA_QUERY_W = 20'h00055;
    localparam logic [19:0] CA_QUERY_B = 20'h000aa;
    localparam logic [19:0] CA_ANY = 20'h00000;

    // Command data bytes
    localparam logic [7:0] CD_UNLOCK1 = 8'haa;
    localparam logic [7:0] CD_UNLOCK2 = 8'h55;
    localparam logic [7:0] CD_RESET = 8'hf0;
    localparam logic [7:0] CD_IDENT = 8'h90;
    localparam logic [7:0] CD_OTP = 8'h88;
    localparam logic [7:0] CD_EXIT2 = 8'h00;
    localparam logic [7:0] CD_QUERY = 8'h98;
    localparam logic [7:0] CD_PROG = 8'ha0;
    localparam logic [7:0] CD_FAST = 8'h20;
    localparam logic [7:0] CD_ERASE = 8'h80;
    localparam logic [7:0] CD_CHIP = 8'h10;
    localparam logic [7:0] CD_SECTOR = 8'h30;
    localparam logic [7:0] CD_SUSPEND = 8'hb0;
    localparam logic [7:0] CD_RESUME = 8'h30;

    typedef enum logic [3:0] {
        OP_READ = 4'h0,
        OP_RESET = 4'h1,
        OP_IDENT = 4'h2,
        OP_OTP_ENTER = 4'h3,
        OP_OTP_EXIT = 4'h4,
        OP_QUERY = 4'h5,
        OP_PROGRAM = 4'h6,
        OP_FAST_ENTER = 4'h7,
        OP_FAST_PROG = 4'h8,
        OP_FAST_EXIT = 4'h9,
        OP_CHIP_ERASE = 4'ha,
        OP_SECTOR_ERASE = 4'hb,
        OP_SECTOR_ADD = 4'hc,
        OP_SUSPEND = 4'hd,
        OP_RESUME = 4'he
    } fcd_op_e;

    typedef enum logic [8:0] {
        M_ARRAY = 9'h001,
        M_IDENT = 9'h002,
        M_OTP = 9'h004,
        M_QUERY = 9'h008,
        M_FAST = 9'h010,
        M_EWIN = 9'h020,
        M_ERASING = 9'h040,
        M_CHIPER = 9'h080,
        M_SUSP = 9'h100
    } fcd_mode_e;

    typedef enum logic [3:0] {
        P_IDLE = 4'h1,
        P_SETUP = 4'h2,
        P_STROBE = 4'h4,
        P_HOLD = 4'h8
    } fcd_phase_e;

    // One bus cycle of a sequence
    typedef struct packed {
        logic last;
        logic wr;
        logic [19:0] addr;
        logic [15:0] data;
    } fcd_cyc_s;

endpackage

// ### fcd_sync.sv
`timescale 1ns/10ps
module fcd_sync
    import fcd_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic [16:0] pin_in,
    output logic [16:0] pin_sync
);

    typedef struct packed {
        logic [16:0] meta;
        logic [16:0] sync;
    } fcd_sync_s;

    fcd_sync_s s_ff;
    fcd_sync_s nxt_s;

    // Two flops; the first is read only by the second
    always_comb begin
        nxt_s.meta = pin_in;
        nxt_s.sync = s_ff.meta;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign pin_sync = s_ff.sync;

endmodule

// ### fcd_cycle.sv
`timescale 1ns/10ps
module fcd_cycle
    import fcd_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic start,
    input wire logic wr,
    input wire logic [19:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] dq_sync,
    output logic done,
    output logic [15:0] rdata,
    output logic [19:0] fl_addr,
    output logic [15:0] fl_dq_o,
    output logic fl_dq_oe,
    output logic fl_ce_n,
    output logic fl_we_n,
    output logic fl_oe_n
);

    typedef struct packed {
        fcd_phase_e phase;
        logic [3:0] cnt;
        logic wr;
        logic done;
        logic [15:0] rdata;
        logic [19:0] addr;
        logic [15:0] dq;
        logic dq_oe;
        logic ce_n;
        logic we_n;
        logic oe_n;
    } fcd_cycle_s;

    fcd_cycle_s s_ff;
    fcd_cycle_s nxt_s;

    // Chip select falls first so write-strobe fall is the later edge;
    // data is held one cycle past the write-strobe rise
    always_comb begin
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        unique case (s_ff.phase)
            P_IDLE: begin
                if (start) begin
                    nxt_s.phase = P_SETUP;
                    nxt_s.wr = wr;
                    nxt_s.addr = addr;
                    nxt_s.dq = wr ? wdata : 16'h0000;
                    nxt_s.dq_oe = wr;
                    nxt_s.ce_n = 1'b0;
                end
            end
            P_SETUP: begin
                nxt_s.phase = P_STROBE;
                nxt_s.we_n = ~s_ff.wr;
                nxt_s.oe_n = s_ff.wr;
                nxt_s.cnt = (s_ff.wr ? WE_LOW_CYC : RD_STROBE_CYC) - 4'd1;
            end
            P_STROBE: begin
                if (s_ff.cnt == 4'h0) begin
                    nxt_s.phase = P_HOLD;
                    nxt_s.we_n = 1'b1;
                    nxt_s.oe_n = 1'b1;
                    if (!s_ff.wr) begin
                        nxt_s.rdata = dq_sync;
                    end
                end else begin
                    nxt_s.cnt = s_ff.cnt - 4'd1;
                end
            end
            P_HOLD: begin
                nxt_s.phase = P_IDLE;
                nxt_s.ce_n = 1'b1;
                nxt_s.dq_oe = 1'b0;
                nxt_s.done = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_ff <= '{phase: P_IDLE, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign done = s_ff.done;
    assign rdata = s_ff.rdata;
    assign fl_addr = s_ff.addr;
    assign fl_dq_o = s_ff.dq;
    assign fl_dq_oe = s_ff.dq_oe;
    assign fl_ce_n = s_ff.ce_n;
    assign fl_we_n = s_ff.we_n;
    assign fl_oe_n = s_ff.oe_n;

    a_we_inside_ce: assert property (
        @(posedge clock) disable iff (srst) !fl_we_n |-> !fl_ce_n && fl_dq_oe && fl_oe_n)
        else $error("write strobe low outside a selected write");

    a_addr_held: assert property (
        @(posedge clock) disable iff (srst) !fl_ce_n && $past(!fl_ce_n) |-> $stable(fl_addr))
        else $error("address moved while chip selected");

    a_data_past_rise: assert property (
        @(posedge clock) disable iff (srst) $rose(fl_we_n) |-> fl_dq_oe && $stable(fl_dq_o) ##1 !fl_dq_oe)
        else $error("write data not held across strobe rise");

    a_write_width: assert property (
        @(posedge clock) disable iff (srst) $fell(fl_we_n) |-> !fl_we_n [*2] ##1 fl_we_n)
        else $error("write strobe width wrong");

endmodule

// ### fcd_host.sv
`timescale 1ns/10ps
// Summary of operation
// - F0 write returns device to array read, or to suspend if identify was entered from suspend
// - Array read is one plain read cycle
// - All sequence cycles write, except reads
// - Identify: three unlock/90 writes, then read
// - Secure region entry: unlock pair, then 88
// - Secure region exit: unlock pair, 90, 00
// - Query 98 only from array or identify
// - Program: unlock pair, A0, location and value
// - Fast mode entry: unlock pair, then 20
// - Fast program: A0 then location and value
// - Fast exit: 90 then 00, or F0
// - Chip erase: six writes ending in 10
// - Sector erase: six writes ending sector/30
// - More sectors queue with single 30 writes
module fcd_host
    import fcd_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic req,
    input fcd_op_e op,
    input wire logic [19:0] addr,
    input wire logic [15:0] wdata,
    input wire logic byte_mode,
    output logic busy,
    output logic done,
    output logic refused,
    output logic [15:0] rdata,
    output logic [8:0] mode_state,
    output logic [19:0] fl_addr,
    output logic [15:0] fl_dq_o,
    output logic fl_dq_oe,
    input wire logic [15:0] fl_dq_i,
    output logic fl_ce_n,
    output logic fl_we_n,
    output logic fl_oe_n,
    input wire logic fl_ready_i
);

    typedef enum logic [2:0] {
        C_IDLE = 3'h1,
        C_ISSUE = 3'h2,
        C_WAIT = 3'h4
    } fcd_ctl_e;

    typedef struct packed {
        fcd_ctl_e ctl;
        fcd_mode_e mode;
        logic susp;
        logic [2:0] step;
        fcd_op_e op;
        logic [19:0] addr;
        logic [15:0] wdata;
        logic bm;
        logic [11:0] win;
        logic [3:0] settle;
        logic start;
        logic done;
        logic refused;
        logic [15:0] rdata;
    } fcd_host_s;

    fcd_host_s s_ff;
    fcd_host_s nxt_s;
    fcd_cyc_s cyc;
    logic [16:0] pins_sync;
    logic [15:0] dq_sync;
    logic rb_ready;
    logic cyc_done;
    logic [15:0] cyc_rdata;
    logic ok;

    // Ready pin and read data both come from outside the clock domain
    fcd_sync u_sync (
        .clock(clock),
        .srst(srst),
        .pin_in({fl_ready_i, fl_dq_i}),
        .pin_sync(pins_sync)
    );
    assign rb_ready = pins_sync[16];
    assign dq_sync = pins_sync[15:0];

    fcd_cycle u_cycle (
        .clock(clock),
        .srst(srst),
        .start(s_ff.start),
        .wr(cyc.wr),
        .addr(cyc.addr),
        .wdata(cyc.data),
        .dq_sync(dq_sync),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .fl_addr(fl_addr),
        .fl_dq_o(fl_dq_o),
        .fl_dq_oe(fl_dq_oe),
        .fl_ce_n(fl_ce_n),
        .fl_we_n(fl_we_n),
        .fl_oe_n(fl_oe_n)
    );

    // Bus cycle for a step of a sequence; upper data byte stays zero on unlock
    // and command cycles, upper address bits on all but the sector/30 cycles
    function automatic fcd_cyc_s seq_step(input fcd_op_e o, input logic [2:0] st, input logic bm,
                                          input logic [19:0] ua, input logic [15:0] ud);
        fcd_cyc_s c;
        logic [19:0] a1;
        logic [19:0] a2;
        a1 = bm ? CA_UNLOCK1_B : CA_UNLOCK1_W;
        a2 = bm ? CA_UNLOCK2_B : CA_UNLOCK2_W;
        c = '{last: 1'b0, wr: 1'b1, addr: a1, data: {8'h00, CD_UNLOCK1}};
        if (st == 3'd1 || st == 3'd4) begin
            c.addr = a2;
            c.data = {8'h00, CD_UNLOCK2};
        end
        unique case (o)
            OP_READ: c = '{last: 1'b1, wr: 1'b0, addr: ua, data: 16'h0000};
            OP_RESET: c = '{last: 1'b1, wr: 1'b1, addr: CA_ANY, data: {8'h00, CD_RESET}};
            OP_QUERY: c = '{last: 1'b1, wr: 1'b1, addr: bm ? CA_QUERY_B : CA_QUERY_W, data: {8'h00, CD_QUERY}};
            OP_SECTOR_ADD: c = '{last: 1'b1, wr: 1'b1, addr: ua, data: {8'h00, CD_SECTOR}};
            OP_SUSPEND: c = '{last: 1'b1, wr: 1'b1, addr: CA_ANY, data: {8'h00, CD_SUSPEND}};
            OP_RESUME: c = '{last: 1'b1, wr: 1'b1, addr: CA_ANY, data: {8'h00, CD_RESUME}};
            OP_FAST_PROG: begin
                c = '{last: 1'b0, wr: 1'b1, addr: CA_ANY, data: {8'h00, CD_PROG}};
                if (st == 3'd1) begin
                    c = '{last: 1'b1, wr: 1'b1, addr: ua, data: ud};
                end
            end
            OP_FAST_EXIT: begin
                c = '{last: 1'b0, wr: 1'b1, addr: CA_ANY, data: {8'h00, CD_IDENT}};
                if (st == 3'd1) begin
                    c = '{last: 1'b1, wr: 1'b1, addr: CA_ANY, data: {8'h00, CD_EXIT2}};
                end
            end
            default: begin
                // Third cycle: command byte at the unlock address
                if (st == 3'd2) begin
                    unique case (o)
                        OP_IDENT: c.data = {8'h00, CD_IDENT};
                        OP_OTP_EXIT: c.data = {8'h00, CD_IDENT};
                        OP_OTP_ENTER: c.data = {8'h00, CD_OTP};
                        OP_PROGRAM: c.data = {8'h00, CD_PROG};
                        OP_FAST_ENTER: c.data = {8'h00, CD_FAST};
                        default: c.data = {8'h00, CD_ERASE};
                    endcase
                    c.last = (o == OP_OTP_ENTER) || (o == OP_FAST_ENTER);
                end
                if (st == 3'd3) begin
                    unique case (o)
                        OP_IDENT: c = '{last: 1'b1, wr: 1'b0, addr: ua, data: 16'h0000};
                        OP_OTP_EXIT: c = '{last: 1'b1, wr: 1'b1, addr: CA_ANY, data: {8'h00, CD_EXIT2}};
                        OP_PROGRAM: c = '{last: 1'b1, wr: 1'b1, addr: ua, data: ud};
                        default: c.addr = a1;
                    endcase
                end
                if (st == 3'd5) begin
                    c.last = 1'b1;
                    c.addr = (o == OP_SECTOR_ERASE) ? ua : a1;
                    c.data = {8'h00, (o == OP_SECTOR_ERASE) ? CD_SECTOR : CD_CHIP};
                end
            end
        endcase
        return c;
    endfunction

    // Which requests the device would honour in its present mode; the
    // rest are refused here rather than sent and silently dropped
    function automatic logic allowed(input fcd_op_e o, input fcd_mode_e m, input logic idle_dev,
                                     input logic [11:0] w);
        logic a;
        a = 1'b0;
        unique case (m)
            M_ARRAY: a = o inside {OP_READ, OP_RESET, OP_IDENT, OP_OTP_ENTER, OP_QUERY, OP_PROGRAM,
                                   OP_FAST_ENTER, OP_CHIP_ERASE, OP_SECTOR_ERASE};
            M_IDENT: a = o inside {OP_READ, OP_RESET, OP_QUERY};
            M_OTP: a = o inside {OP_READ, OP_PROGRAM, OP_OTP_EXIT};
            M_QUERY: a = o inside {OP_READ, OP_RESET};
            M_FAST: a = o inside {OP_READ, OP_FAST_PROG, OP_FAST_EXIT, OP_RESET};
            M_EWIN: a = (o == OP_READ) || (o == OP_SUSPEND) || (o == OP_SECTOR_ADD && w < WIN_ACCEPT_CYC);
            M_ERASING: a = o inside {OP_READ, OP_SUSPEND};
            M_CHIPER: a = (o == OP_READ);
            M_SUSP: a = o inside {OP_READ, OP_PROGRAM, OP_IDENT, OP_RESUME};
            default: a = 1'b0;
        endcase
        // Embedded program still running: only reads go out
        if (!idle_dev && o != OP_READ && !(m inside {M_EWIN, M_ERASING, M_CHIPER})) begin
            a = 1'b0;
        end
        return a;
    endfunction

    assign cyc = seq_step(s_ff.op, s_ff.step, s_ff.bm, s_ff.addr, s_ff.wdata);
    assign ok = allowed(op, s_ff.mode, rb_ready && s_ff.settle == 4'h0, s_ff.win);

    // Sequencer and device mode tracker
    always_comb begin
        nxt_s = s_ff;
        nxt_s.start = 1'b0;
        nxt_s.done = 1'b0;
        nxt_s.refused = 1'b0;
        if (s_ff.settle != 4'h0) begin
            nxt_s.settle = s_ff.settle - 4'd1;
        end
        // Queue window runs out, erasure starts
        if (s_ff.mode == M_EWIN) begin
            if (s_ff.win >= ERASE_WIN_CYC) begin
                nxt_s.mode = M_ERASING;
            end else begin
                nxt_s.win = s_ff.win + 12'd1;
            end
        end
        // Ready pin is ignored until the device had time to pull it low
        if ((s_ff.mode == M_ERASING || s_ff.mode == M_CHIPER) && s_ff.settle == 4'h0 && rb_ready) begin
            nxt_s.mode = M_ARRAY;
        end
        unique case (s_ff.ctl)
            C_IDLE: begin
                if (req) begin
                    if (ok) begin
                        nxt_s.ctl = C_ISSUE;
                        nxt_s.op = op;
                        nxt_s.addr = addr;
                        nxt_s.wdata = wdata;
                        nxt_s.bm = byte_mode;
                        nxt_s.step = 3'd0;
                    end else begin
                        nxt_s.refused = 1'b1;
                    end
                end
            end
            C_ISSUE: begin
                nxt_s.start = 1'b1;
                nxt_s.ctl = C_WAIT;
            end
            C_WAIT: begin
                if (cyc_done && !cyc.last) begin
                    nxt_s.step = s_ff.step + 3'd1;
                    nxt_s.ctl = C_ISSUE;
                end
                if (cyc_done && cyc.last) begin
                    nxt_s.ctl = C_IDLE;
                    nxt_s.done = 1'b1;
                    if (cyc.wr) begin
                        nxt_s.settle = BUSY_CYC;
                    end else begin
                        nxt_s.rdata = cyc_rdata;
                    end
                    unique case (s_ff.op)
                        OP_RESET: nxt_s.mode = (s_ff.mode == M_IDENT && s_ff.susp) ? M_SUSP : M_ARRAY;
                        OP_IDENT: begin
                            nxt_s.mode = M_IDENT;
                            nxt_s.susp = (s_ff.mode == M_SUSP);
                        end
                        OP_OTP_ENTER: nxt_s.mode = M_OTP;
                        OP_OTP_EXIT: nxt_s.mode = M_ARRAY;
                        OP_QUERY: nxt_s.mode = M_QUERY;
                        OP_FAST_ENTER: nxt_s.mode = M_FAST;
                        OP_FAST_EXIT: nxt_s.mode = M_ARRAY;
                        OP_CHIP_ERASE: nxt_s.mode = M_CHIPER;
                        OP_SECTOR_ERASE, OP_SECTOR_ADD: begin
                            nxt_s.mode = M_EWIN;
                            nxt_s.win = 12'h000;
                        end
                        OP_SUSPEND: nxt_s.mode = M_SUSP;
                        OP_RESUME: nxt_s.mode = M_ERASING;
                        default: nxt_s.mode = s_ff.mode;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            s_ff <= '{ctl: C_IDLE, mode: M_ARRAY, op: OP_READ, default: '0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Ready for a request only when idle
    assign busy = (s_ff.ctl != C_IDLE);
    assign done = s_ff.done;
    assign refused = s_ff.refused;
    assign rdata = s_ff.rdata;
    assign mode_state = s_ff.mode;

    a_reset_code: assert property (
        @(posedge clock) disable iff (srst) s_ff.start && s_ff.op == OP_RESET |-> cyc.wr && cyc.data == 16'h00f0)
        else $error("reset cycle without F0");

    a_unlock_low: assert property (
        @(posedge clock) disable iff (srst)
        s_ff.start && s_ff.step == 3'd0 && s_ff.op == OP_PROGRAM |-> cyc.data[15:8] == 8'h00 && cyc.addr[19:11] == 9'h000)
        else $error("unlock cycle with upper bits set");

    a_query_gate: assert property (
        @(posedge clock) disable iff (srst)
        req && !busy && op == OP_QUERY && !(s_ff.mode inside {M_ARRAY, M_IDENT}) |=> refused && !busy)
        else $error("query accepted outside array or identify");

    a_suspend_gate: assert property (
        @(posedge clock) disable iff (srst)
        req && !busy && op == OP_SUSPEND && !(s_ff.mode inside {M_EWIN, M_ERASING}) |=> refused)
        else $error("suspend accepted outside sector erase");

    a_resume_gate: assert property (
        @(posedge clock) disable iff (srst) req && !busy && op == OP_RESUME && s_ff.mode != M_SUSP |=> refused)
        else $error("resume accepted while not suspended");

    a_fast_filter: assert property (
        @(posedge clock) disable iff (srst)
        req && !busy && s_ff.mode == M_FAST && !(op inside {OP_READ, OP_FAST_PROG, OP_FAST_EXIT, OP_RESET})
        |=> refused)
        else $error("foreign command sent in fast mode");

    a_chip_ignore: assert property (
        @(posedge clock) disable iff (srst) req && !busy && s_ff.mode == M_CHIPER && op != OP_READ |=> refused)
        else $error("command sent during chip erase");

    a_window_max: assert property (
        @(posedge clock) disable iff (srst)
        s_ff.mode == M_EWIN && s_ff.win == ERASE_WIN_CYC && !(s_ff.ctl == C_WAIT && cyc_done && cyc.last)
        |=> s_ff.mode == M_ERASING)
        else $error("queue window not closed on time");

endmodule

// ### fcd_flash_model.sv
`timescale 1ns/10ps
module fcd_flash_model (
    input wire logic clock,
    input wire logic [19:0] fl_addr,
    input wire logic [15:0] fl_dq_o,
    input wire logic fl_dq_oe,
    input wire logic fl_ce_n,
    input wire logic fl_we_n,
    input wire logic fl_oe_n,
    output logic [15:0] fl_dq_i,
    output logic fl_ready_i
);
    logic [19:0] log_a [0:63];
    logic [15:0] log_d [0:63];
    logic [19:0] lat_a;
    logic [15:0] q = 16'h0000;
    int n_wr = 0;
    // Pull-up only; the embedded algorithms are not modelled
    assign fl_ready_i = 1'b1;
    // Address taken at whichever strobe falls last
    always @(negedge fl_we_n or negedge fl_ce_n) begin
        if (!fl_we_n && !fl_ce_n) lat_a = fl_addr;
    end
    // Data taken at whichever strobe rises first
    always @(posedge fl_we_n or posedge fl_ce_n) begin
        if ((fl_we_n ^ fl_ce_n) && n_wr < 64) begin
            log_a[n_wr] = lat_a;
            log_d[n_wr] = fl_dq_o;
            n_wr++;
        end
    end
    // Array or code read; outside a read the bus toggles so stale data never looks valid
    always @(posedge clock) begin
        if (!fl_ce_n && !fl_oe_n && !fl_dq_oe) q <= fl_addr[15:0] ^ 16'h3c3c;
        else q <= ~q;
    end
    assign fl_dq_i = q;
endmodule

// ### fcd_host_tb_top.sv
`timescale 1ns/10ps
module fcd_host_tb_top;
    import fcd_pkg::*;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic req = 1'b0;
    fcd_op_e op = OP_READ;
    logic [19:0] addr = 20'h00000;
    logic [15:0] wdata = 16'h0000;
    logic byte_mode = 1'b0;
    logic busy, done, refused, fl_dq_oe, fl_ce_n, fl_we_n, fl_oe_n, fl_ready_i, rf;
    logic [15:0] rdata, fl_dq_o, fl_dq_i;
    logic [8:0] mode_state;
    logic [19:0] fl_addr;
    int miscompares = 0;
    int n_compared = 0;
    int base;
    always #10 clock = ~clock;
    fcd_host i_dut (.clock(clock), .srst(srst), .req(req), .op(op), .addr(addr), .wdata(wdata),
        .byte_mode(byte_mode), .busy(busy), .done(done), .refused(refused), .rdata(rdata),
        .mode_state(mode_state), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
        .fl_dq_i(fl_dq_i), .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_ready_i(fl_ready_i));
    fcd_flash_model i_model (.clock(clock), .fl_addr(fl_addr), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe),
        .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_dq_i(fl_dq_i), .fl_ready_i(fl_ready_i));
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // Gap first, so the ready pin is trusted again before the next request
    task automatic run(input fcd_op_e o, input logic [19:0] a, input logic [15:0] d);
        int i;
        repeat (8) @(negedge clock);
        base = i_model.n_wr;
        req = 1'b1;
        op = o;
        addr = a;
        wdata = d;
        @(negedge clock);
        req = 1'b0;
        for (i = 0; i < 60 && done !== 1'b1 && refused !== 1'b1; i++) @(negedge clock);
        rf = refused;
        if (i == 60) begin
            miscompares++;
            wrap_up();
        end
    endtask
    task automatic w(input int k, input logic [19:0] a, input logic [15:0] d);
        chk(i_model.log_a[base + k], a);
        chk(i_model.log_d[base + k], d);
    endtask
    initial begin
        repeat (5) @(negedge clock);
        srst = 1'b0;
        run(OP_RESET, 20'h00000, 16'h0000);
        w(0, 20'h00000, 16'h00f0);
        run(OP_PROGRAM, 20'h12345, 16'hbeef);
        w(2, 20'h00555, 16'h00a0);
        w(3, 20'h12345, 16'hbeef);
        run(OP_READ, 20'h00a5a, 16'h0000);
        chk(rdata, 16'h0a5a ^ 16'h3c3c);
        chk(20'(i_model.n_wr - base), 20'h00000);
        byte_mode = 1'b1;
        run(OP_IDENT, 20'h00002, 16'h0000);
        w(0, 20'h00aaa, 16'h00aa);
        w(1, 20'h00555, 16'h0055);
        w(2, 20'h00aaa, 16'h0090);
        chk(rdata, 16'h0002 ^ 16'h3c3c);
        run(OP_QUERY, 20'h00000, 16'h0000);
        w(0, 20'h000aa, 16'h0098);
        chk(mode_state, 9'h008);
        byte_mode = 1'b0;
        run(OP_RESET, 20'h00000, 16'h0000);
        chk(mode_state, 9'h001);
        run(OP_FAST_ENTER, 20'h00000, 16'h0000);
        w(2, 20'h00555, 16'h0020);
        run(OP_QUERY, 20'h00000, 16'h0000);
        chk(rf, 1'b1);
        run(OP_FAST_PROG, 20'h00777, 16'h1234);
        chk(i_model.log_d[base], 16'h00a0);
        w(1, 20'h00777, 16'h1234);
        run(OP_FAST_EXIT, 20'h00000, 16'h0000);
        chk(i_model.log_d[base + 1], 16'h0000);
        chk(mode_state, 9'h001);
        run(OP_FAST_PROG, 20'h00777, 16'h1234);
        chk(rf, 1'b1);
        run(OP_OTP_ENTER, 20'h00000, 16'h0000);
        w(2, 20'h00555, 16'h0088);
        run(OP_QUERY, 20'h00000, 16'h0000);
        chk(rf, 1'b1);
        run(OP_OTP_EXIT, 20'h00000, 16'h0000);
        w(2, 20'h00555, 16'h0090);
        chk(i_model.log_d[base + 3], 16'h0000);
        run(OP_SUSPEND, 20'h00000, 16'h0000);
        chk(rf, 1'b1);
        run(OP_RESUME, 20'h00000, 16'h0000);
        chk(rf, 1'b1);
        run(OP_SECTOR_ERASE, 20'h34000, 16'h0000);
        w(2, 20'h00555, 16'h0080);
        w(5, 20'h34000, 16'h0030);
        chk(mode_state, 9'h020);
        run(OP_SECTOR_ADD, 20'h56000, 16'h0000);
        w(0, 20'h56000, 16'h0030);
        run(OP_SUSPEND, 20'h00000, 16'h0000);
        chk(i_model.log_d[base], 16'h00b0);
        chk(mode_state, 9'h100);
        run(OP_RESUME, 20'h00000, 16'h0000);
        chk(i_model.log_d[base], 16'h0030);
        // Erase ends once the ready pin is seen high after the settle time
        repeat (20) @(negedge clock);
        run(OP_CHIP_ERASE, 20'h00000, 16'h0000);
        w(3, 20'h00555, 16'h00aa);
        w(5, 20'h00555, 16'h0010);
        // Let a queue window run out: late add refused, then erasure and back to array
        run(OP_SECTOR_ERASE, 20'h78000, 16'h0000);
        repeat (2480) @(negedge clock);
        chk(mode_state, 9'h020);
        run(OP_SECTOR_ADD, 20'h9a000, 16'h0000);
        chk(rf, 1'b1);
        repeat (20) @(negedge clock);
        chk(mode_state, 9'h001);
        wrap_up();
    end
endmodule
